/* File: core/tta_pkg.sv */
// Purpose : Shared constants and types for the timer event, interrupt and sleep block
// Assumes : 32-bit Avalon-MM data, registers one per word, byte address = index * 4
// Notes   : Action-select codes and flag bit positions are shared with software

package tta_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL_FIRST  = 8'h00; // First control register
    localparam logic [7:0] IDX_CTRL_SPLIT  = 8'h03; // Split select
    localparam logic [7:0] IDX_CTRL_DIR    = 8'h04; // Software count direction
    localparam logic [7:0] IDX_EVENT_CONTROL_REGISTER      = 8'h09; // Event control register
    localparam logic [7:0] IDX_INT_ENABLE  = 8'h0a; // Interrupt enable register
    localparam logic [7:0] IDX_INT_FLAGS   = 8'h0b; // Interrupt flag register
    localparam logic [7:0] IDX_COUNT       = 8'h20; // Counter value
    localparam logic [7:0] IDX_PERIOD      = 8'h26; // Period (top)
    localparam logic [7:0] IDX_COMPARE0    = 8'h28; // Compare 0; 1 and 2 follow every two

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_ENABLE     = 0;
    localparam int BIT_CLKSEL_LO  = 1;
    localparam int BIT_RUN_STDBY  = 7;
    localparam int BIT_SPLIT      = 0;
    localparam int BIT_DIR        = 0;
    localparam int BIT_FIRST_EN   = 0;
    localparam int BIT_FIRST_ACT  = 1;
    localparam int BIT_SECOND_EN  = 4;
    localparam int BIT_SECOND_ACT = 5;
    localparam int BIT_FLAG_OVF   = 0; // Overflow / low-byte underflow
    localparam int BIT_FLAG_HIGH_BYTE_UNDERFLOW  = 1; // High-byte underflow, split only
    localparam int BIT_FLAG_COMPARE0_FLAG  = 4; // Compare 0..2 at 4..6
    localparam logic [7:0] FLAG_MASK = 8'h73;

    // ------------------------------------------------------------
    // Event action codes
    // ------------------------------------------------------------
    localparam logic [2:0] ACT_CNT_POS   = 3'h0;
    localparam logic [2:0] ACT_CNT_ANY   = 3'h1;
    localparam logic [2:0] ACT_CNT_HIGH  = 3'h2;
    localparam logic [2:0] ACT_DIR       = 3'h3;
    localparam logic [2:0] ACT_RST_POS   = 3'h4;
    localparam logic [2:0] ACT_RST_ANY   = 3'h5;
    localparam logic [2:0] ACT_RST_HIGH  = 3'h6;

    // Prescaler masks (divisor - 1) for clock-select codes 0..7
    localparam logic [9:0] PRE_DIV1    = 10'h000;
    localparam logic [9:0] PRE_DIV2    = 10'h001;
    localparam logic [9:0] PRE_DIV4    = 10'h003;
    localparam logic [9:0] PRE_DIV8    = 10'h007;
    localparam logic [9:0] PRE_DIV16   = 10'h00f;
    localparam logic [9:0] PRE_DIV64   = 10'h03f;
    localparam logic [9:0] PRE_DIV256  = 10'h0ff;
    localparam logic [9:0] PRE_DIV1024 = 10'h3ff;

    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // Event generator outputs toward the routing network
    typedef struct packed {
        logic       high_byte_underflow;     // High-byte underflow (split only)
        logic [2:0] cmp;      // Compare / low-byte compare events
        logic       overflow_low_underflow_event; // Overflow / low-byte underflow
    } tta_evt_t;

endpackage

/* File: core/tta_timer.sv */
// Purpose : Event generation, event-input actions, interrupt flags and sleep gating of a
//           16-bit timer that may run split as two 8-bit down-counters
// Assumes : Event inputs and sleep indications synchronous to sys_clk_i
// Notes   : Registers on Avalon-MM, one answer cycle of wait after each request
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps

module tta_timer #(
    parameter int CNT_W = 16 // Counter width, split uses two halves
) (
    input  wire logic              sys_clk_i,         // 10 MHz peripheral clock
    input  wire logic              rst_i,             // Async reset, active high
    input  wire logic [7:0]        avs_address_i,     // Word index
    input  wire logic              avs_read_i,        // Read request
    input  wire logic              avs_write_i,       // Write request
    input  wire logic [31:0]       avs_writedata_i,   // Write data
    input  wire logic [3:0]        avs_byteenable_i,  // Byte lanes
    output logic [31:0]            avs_readdata_o,    // Read data
    output logic                   avs_waitrequest_o, // Low for the answering cycle
    input  wire logic              event_input_first_i,  // Event input, first user
    input  wire logic              event_input_second_i, // Event input, second user
    input  wire logic              sleep_standby_i,   // System in standby sleep
    input  wire logic              sleep_powerdown_i, // System in power-down sleep
    output tta_pkg::tta_evt_t      evt_o,             // Event pulses to routing network
    output logic                   irq_o              // Interrupt request
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (CNT_W != 16) begin : g_bad_width
        $error("tta_timer: split mode needs CNT_W of 16");
    end

    localparam int HB = CNT_W / 2;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic             enable;
    logic [2:0]       clksel;
    logic             run_in_standby;
    logic             split;
    logic             dir_down_sw;
    logic             first_input_enable;
    logic [2:0]       first_input_action_select;
    logic             second_input_enable;
    logic [2:0]       second_input_action_select;
    logic [7:0]       int_enable;
    logic [7:0]       int_flags;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] per;
    logic [CNT_W-1:0] cmp [3];
    logic [9:0]       pre_cnt;
    logic             ev_first_q;
    logic             ev_second_q;

    logic             bus_req;
    logic             bus_wr;
    logic [31:0]      wdata;
    logic             run;
    logic [9:0]       pre_mask;
    logic             tick;
    logic             first_on;
    logic             second_on;
    logic             step;
    logic             restart;
    logic             count_down;
    logic [7:0]       next_set;
    logic [CNT_W-1:0] next_cnt;

    assign bus_req = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    assign bus_wr  = avs_write_i & ~avs_waitrequest_o;

    // Byte-enable merge into a 32-bit word, unused lanes stay zero
    always_comb begin
        wdata = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            if (avs_byteenable_i[b]) begin
                wdata[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
            end
        end
    end

    // ------------------------------------------------------------
    // Sleep gating and prescaler
    // ------------------------------------------------------------
    // Power-down always wins; standby halts unless software allows it
    assign run = enable & ~sleep_powerdown_i & (~sleep_standby_i | run_in_standby);

    always_comb begin
        case (clksel)
            3'h0:    pre_mask = tta_pkg::PRE_DIV1;
            3'h1:    pre_mask = tta_pkg::PRE_DIV2;
            3'h2:    pre_mask = tta_pkg::PRE_DIV4;
            3'h3:    pre_mask = tta_pkg::PRE_DIV8;
            3'h4:    pre_mask = tta_pkg::PRE_DIV16;
            3'h5:    pre_mask = tta_pkg::PRE_DIV64;
            3'h6:    pre_mask = tta_pkg::PRE_DIV256;
            default: pre_mask = tta_pkg::PRE_DIV1024;
        endcase
    end

    assign tick = run & ((pre_cnt & pre_mask) == pre_mask);

    // Prescaler freezes with the timer so sleep resumes mid-period
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt <= 10'h000;
        end else if (!enable) begin
            pre_cnt <= 10'h000;
        end else if (run) begin
            pre_cnt <= pre_cnt + 10'h001;
        end
    end

    // ------------------------------------------------------------
    // Event input actions
    // ------------------------------------------------------------
    // Previous levels for edge detection, sampled on every clock
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ev_first_q  <= 1'b0;
            ev_second_q <= 1'b0;
        end else begin
            ev_first_q  <= event_input_first_i;
            ev_second_q <= event_input_second_i;
        end
    end

    // Inputs act only while enabled, and never in split mode
    assign first_on  = first_input_enable & ~split;
    assign second_on = second_input_enable & ~split;

    // Count source: first-input edges replace the prescaler tick, a high first-input level gates it
    always_comb begin
        step = tick;
        if (first_on) begin
            case (first_input_action_select)
                tta_pkg::ACT_CNT_POS:  step = run & event_input_first_i & ~ev_first_q;
                tta_pkg::ACT_CNT_ANY:  step = run & (event_input_first_i ^ ev_first_q);
                tta_pkg::ACT_CNT_HIGH: step = tick & event_input_first_i;
                default:               step = tick;
            endcase
        end
    end

    // Restart from the second input
    always_comb begin
        restart = 1'b0;
        if (second_on && run) begin
            case (second_input_action_select)
                tta_pkg::ACT_RST_POS:  restart = event_input_second_i & ~ev_second_q;
                tta_pkg::ACT_RST_ANY:  restart = event_input_second_i ^ ev_second_q;
                tta_pkg::ACT_RST_HIGH: restart = event_input_second_i;
                default:               restart = 1'b0;
            endcase
        end
    end

    // Direction: levels OR'ed with the software bit, up only when all low
    assign count_down = dir_down_sw
        | (first_on  && first_input_action_select  == tta_pkg::ACT_DIR && event_input_first_i)
        | (second_on && second_input_action_select == tta_pkg::ACT_DIR && event_input_second_i);

    // ------------------------------------------------------------
    // Counter and flag-set conditions
    // ------------------------------------------------------------
    always_comb begin
        next_set = 8'h00;
        next_cnt = cnt;
        if (restart) begin
            next_cnt = '0;
        end else if (split) begin
            // Two independent down-counters, each reloading from its period byte
            if (tick) begin
                next_cnt[HB-1:0] = cnt[HB-1:0] - 8'h01;
                next_cnt[CNT_W-1:HB] = cnt[CNT_W-1:HB] - 8'h01;
                if (cnt[HB-1:0] == 8'h00) begin
                    next_cnt[HB-1:0] = per[HB-1:0];
                    next_set[tta_pkg::BIT_FLAG_OVF] = 1'b1;
                end
                if (cnt[CNT_W-1:HB] == 8'h00) begin
                    next_cnt[CNT_W-1:HB] = per[CNT_W-1:HB];
                    next_set[tta_pkg::BIT_FLAG_HIGH_BYTE_UNDERFLOW] = 1'b1;
                end
                for (int n = 0; n < 3; n++) begin
                    if (cnt[HB-1:0] == cmp[n][HB-1:0]) begin
                        next_set[tta_pkg::BIT_FLAG_COMPARE0_FLAG + n] = 1'b1;
                    end
                end
            end
        end else if (step) begin
            if (count_down) begin
                next_cnt = (cnt == '0) ? per : cnt - 16'h0001;
                next_set[tta_pkg::BIT_FLAG_OVF] = (cnt == '0);
            end else begin
                next_cnt = (cnt == per) ? '0 : cnt + 16'h0001;
                next_set[tta_pkg::BIT_FLAG_OVF] = (cnt == per);
            end
            for (int n = 0; n < 3; n++) begin
                if (cnt == cmp[n]) begin
                    next_set[tta_pkg::BIT_FLAG_COMPARE0_FLAG + n] = 1'b1;
                end
            end
        end
    end

    // Counter: a software write overrides counting in the same cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (bus_wr && avs_address_i == tta_pkg::IDX_COUNT) begin
            cnt <= wdata[CNT_W-1:0];
        end else begin
            cnt <= next_cnt;
        end
    end

    // ------------------------------------------------------------
    // Event outputs and interrupt
    // ------------------------------------------------------------
    // Events are the flag-set strobes themselves, registered once
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt_o <= '0;
        end else begin
            evt_o.overflow_low_underflow_event <= next_set[tta_pkg::BIT_FLAG_OVF];
            evt_o.high_byte_underflow     <= next_set[tta_pkg::BIT_FLAG_HIGH_BYTE_UNDERFLOW] & split;
            evt_o.cmp      <= next_set[tta_pkg::BIT_FLAG_COMPARE0_FLAG +: 3];
        end
    end

    // Sticky flags: hardware set wins over a write-one clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_flags <= 8'h00;
        end else if (bus_wr && avs_address_i == tta_pkg::IDX_INT_FLAGS) begin
            int_flags <= ((int_flags & ~wdata[7:0]) | next_set) & tta_pkg::FLAG_MASK;
        end else begin
            int_flags <= (int_flags | next_set) & tta_pkg::FLAG_MASK;
        end
    end

    // Request held while any enabled flag stays set
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(int_flags & int_enable);
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Control fields; all writable at any time
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable                     <= 1'b0;
            clksel                     <= 3'h0;
            run_in_standby             <= 1'b0;
            split                      <= 1'b0;
            dir_down_sw                <= 1'b0;
            first_input_enable         <= 1'b0;
            first_input_action_select  <= 3'h0;
            second_input_enable        <= 1'b0;
            second_input_action_select <= 3'h0;
            int_enable                 <= 8'h00;
            per                        <= '1;
        end else if (bus_wr) begin
            case (avs_address_i)
                tta_pkg::IDX_CTRL_FIRST: begin
                    enable         <= wdata[tta_pkg::BIT_ENABLE];
                    clksel         <= wdata[tta_pkg::BIT_CLKSEL_LO +: 3];
                    run_in_standby <= wdata[tta_pkg::BIT_RUN_STDBY];
                end
                tta_pkg::IDX_CTRL_SPLIT: split       <= wdata[tta_pkg::BIT_SPLIT];
                tta_pkg::IDX_CTRL_DIR:   dir_down_sw <= wdata[tta_pkg::BIT_DIR];
                tta_pkg::IDX_EVENT_CONTROL_REGISTER: begin
                    first_input_enable         <= wdata[tta_pkg::BIT_FIRST_EN];
                    first_input_action_select  <= wdata[tta_pkg::BIT_FIRST_ACT +: 3];
                    second_input_enable        <= wdata[tta_pkg::BIT_SECOND_EN];
                    second_input_action_select <= wdata[tta_pkg::BIT_SECOND_ACT +: 3];
                end
                tta_pkg::IDX_INT_ENABLE: int_enable <= wdata[7:0] & tta_pkg::FLAG_MASK;
                tta_pkg::IDX_PERIOD:     per        <= wdata[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // Compare registers, one per channel
    for (genvar n = 0; n < 3; n++) begin : g_cmp
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                cmp[n] <= '0;
            end else if (bus_wr && avs_address_i == tta_pkg::IDX_COMPARE0 + 8'(2 * n)) begin
                cmp[n] <= wdata[CNT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM answer
    // ------------------------------------------------------------
    // One wait cycle per request keeps read data registered
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
        end
    end

    // Read mux; unmapped words read zero
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            case (avs_address_i)
                tta_pkg::IDX_CTRL_FIRST: avs_readdata_o <= {24'h000000, run_in_standby, 3'h0, clksel, enable};
                tta_pkg::IDX_CTRL_SPLIT: avs_readdata_o <= {31'h0, split};
                tta_pkg::IDX_CTRL_DIR:   avs_readdata_o <= {31'h0, dir_down_sw};
                tta_pkg::IDX_EVENT_CONTROL_REGISTER:     avs_readdata_o <= {24'h000000, second_input_action_select,
                                             second_input_enable, first_input_action_select, first_input_enable};
                tta_pkg::IDX_INT_ENABLE: avs_readdata_o <= {24'h000000, int_enable};
                tta_pkg::IDX_INT_FLAGS:  avs_readdata_o <= {24'h000000, int_flags};
                tta_pkg::IDX_COUNT:      avs_readdata_o <= {16'h0000, cnt};
                tta_pkg::IDX_PERIOD:     avs_readdata_o <= {16'h0000, per};
                tta_pkg::IDX_COMPARE0:   avs_readdata_o <= {16'h0000, cmp[0]};
                8'h2a:                   avs_readdata_o <= {16'h0000, cmp[1]};
                8'h2c:                   avs_readdata_o <= {16'h0000, cmp[2]};
                default:                 avs_readdata_o <= tta_pkg::RD_UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    event_sets_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        evt_o.overflow_low_underflow_event |-> int_flags[tta_pkg::BIT_FLAG_OVF])
        else $error("overflow event without its flag");

    high_byte_underflow_split_only_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        evt_o.high_byte_underflow |-> $past(split))
        else $error("high-byte underflow event outside split mode");

    cmp_match_event_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (evt_o.cmp[0] && !$past(split)) |-> ($past(cnt) == $past(cmp[0])))
        else $error("compare 0 event without counter match");

    irq_follows_flags_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ##1 irq_o == $past(|(int_flags & int_enable)))
        else $error("interrupt request not tied to enabled flags");

    powerdown_halts_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (sleep_powerdown_i && !bus_wr) |=> (cnt == $past(cnt) && !evt_o.overflow_low_underflow_event))
        else $error("counter moved in power-down");

    standby_halts_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (sleep_standby_i && !run_in_standby && !bus_wr) |=> $stable(cnt))
        else $error("counter moved in standby without run-in-standby");

    flag_w1c_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (bus_wr && avs_address_i == tta_pkg::IDX_INT_FLAGS && wdata[tta_pkg::BIT_FLAG_OVF]
         && !next_set[tta_pkg::BIT_FLAG_OVF]) |=> !int_flags[tta_pkg::BIT_FLAG_OVF])
        else $error("write-one did not clear flag");

    restart_high_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (second_on && run && second_input_action_select == tta_pkg::ACT_RST_HIGH
         && event_input_second_i && !bus_wr) |=> (cnt == '0))
        else $error("restart-while-high did not clear counter");

endmodule

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the timer event block
// Assumes: Avalon-MM, one wait cycle per request
// Notes: Event input first used as direction control
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst = 1, rd = 0, we = 0, sa = 0, sb = 0, ss = 0, sp = 0, wt, irq;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, q, c1, rdat;
    logic [4:0]  seen;
    int          mismatches = 0, check_count = 0, n;
    tta_pkg::tta_evt_t ev;
    // ----------------------------------------
    // Clock, design and far side
    // ----------------------------------------
    always #50 clk = ~clk;
    tta_timer u_dut (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(we),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
        .event_input_first_i(sa), .event_input_second_i(sb), .sleep_standby_i(ss),
        .sleep_powerdown_i(sp), .evt_o(ev), .irq_o(irq));
    tta_evt_sink u_sink (.clk_i(clk), .rst_i(rst), .evt_i(ev), .seen_o(seen));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One bus access; extra edge keeps strobes from re-rising in one step
    task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
        adr <= a; wd <= d; we <= w; rd <= !w;
        @(posedge clk);
        while (wt !== 1'b0) @(posedge clk);
        q = rdat; we <= 0; rd <= 0;
        @(posedge clk);
    endtask
    task automatic wait_ev(input int b);
        n = 0;
        while (ev[b] !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n < 100), 1);
    endtask
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        acc(8'h0b, 0, 0); chk(q, 0);
        acc(8'h50, 0, 0); chk(q, 0);
        acc(8'h26, 1, 3); acc(8'h0a, 1, 1); acc(8'h00, 1, 1);
        wait_ev(0);
        @(posedge clk); chk(ev.overflow_low_underflow_event, 0);
        chk(seen[4], 0);
        chk(seen[3:1], 3'h7);
        chk(irq, 1);
        acc(8'h0b, 1, 0); chk(irq, 1);
        acc(8'h00, 1, 0); acc(8'h0b, 1, 1); acc(8'h0b, 0, 0); chk(q, 32'h70); chk(irq, 0);
        // Standby and power-down gating, counting down by event level
        ss <= 1; sa <= 1; acc(8'h09, 1, 7); acc(8'h20, 1, 32'h100); acc(8'h00, 1, 1);
        acc(8'h20, 0, 0); c1 = q; acc(8'h20, 0, 0); chk(q, c1);
        acc(8'h00, 1, 32'h81); acc(8'h20, 0, 0); chk(32'(q < c1), 1);
        sp <= 1; acc(8'h20, 0, 0); c1 = q; acc(8'h20, 0, 0); chk(q, c1);
        // Counting on first-input edges: rising only, then any edge
        ss <= 0; sp <= 0; sa <= 0; acc(8'h26, 1, 32'hff);
        for (int k = 0; k < 2; k++) begin
            acc(8'h09, 1, 32'(1 + 2 * k)); acc(8'h20, 1, 0);
            repeat (3) begin
                sa <= 1; @(posedge clk);
                sa <= 0; @(posedge clk);
            end
            acc(8'h20, 0, 0); chk(q, 32'(3 + 3 * k));
        end
        // Both inputs set to steer direction, only the second input driven; levels held well past one tick
        sb <= 1; acc(8'h09, 1, 32'h77); acc(8'h20, 1, 32'h80);
        acc(8'h20, 0, 0); chk(32'(q < 32'h80), 1);
        sb <= 0; acc(8'h20, 1, 32'h80); acc(8'h20, 0, 0); chk(32'(q > 32'h80), 1);
        // Second input restarts while high
        sb <= 1; acc(8'h09, 1, 32'hd0); acc(8'h20, 0, 0); chk(q, 0);
        // Split mode high-byte underflow; the held restart must stay ignored
        acc(8'h00, 1, 0); acc(8'h03, 1, 1);
        acc(8'h26, 1, 32'h0303); acc(8'h0a, 1, 2); acc(8'h00, 1, 1);
        wait_ev(4);
        acc(8'h0b, 0, 0); chk(q[1], 1); chk(irq, 1);
        end_of_test;
    end
    // Watchdog, far beyond the roughly 150 cycles needed
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        end_of_test;
    end
endmodule

/* File: test/tta_evt_sink.sv */
// Purpose: Routing network stand-in, latches every event pulse seen
// Assumes: Pulses synchronous to the peripheral clock
// Notes: Sticky so the bench can look after the fact
`timescale 1ns/1ps
module tta_evt_sink (
    input  wire logic              clk_i,  // Peripheral clock
    input  wire logic              rst_i,  // Async reset
    input  wire tta_pkg::tta_evt_t evt_i,  // Event pulses
    output logic [4:0]             seen_o  // Sticky per line
);
    // Sticky capture, a missed single pulse would hide a fault
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) seen_o <= 5'h00;
        else seen_o <= seen_o | evt_i;
    end
endmodule
